// ### src/exec_timing_defs.svh
`ifndef EXEC_TIMING_DEFS_SVH
`define EXEC_TIMING_DEFS_SVH
// Functional notes
// - Total states equal counts times per-cycle costs.
// - Fetch, branch, stack cycles cost 2/6/6+2m.
// - Byte access costs 2, 3 or 3+m.
// - Word access costs 2, 6 or 6+2m.
// - Internal operation always costs one state.
// - External costs grow by supplied wait count m for bytes, 2m for others.
// - Fixed counts; ALU/flags one fetch, branches two.
// - Bit logic/clear memory forms add byte accesses.
// - Memory bit set: two fetches, two bytes.
// - Quoted totals assume everything in on-chip memory.

// ==========================================================
// Cycle costs in states.
`define COST_ONCHIP_MEM 6'h02
`define COST_BUS_BASE 6'h06
`define COST_BYTE_BASE 6'h03
`define COST_INTERNAL 6'h01

// ==========================================================
// Cycle counts and reset values.
`define N_ONE 2'h1
`define N_TWO 2'h2
`define TOTAL_RST 8'h00
`define COST_RST 6'h00
`endif

// ### src/exec_timing_pkg.sv
package exec_timing_pkg;
    typedef enum logic [2:0] {
        CY_FETCH = 3'h0,
        CY_BRANCH_READ = 3'h1,
        CY_STACK = 3'h2,
        CY_BYTE = 3'h3,
        CY_WORD = 3'h4,
        CY_INTERNAL = 3'h5
    } cycle_e;
    typedef enum logic [1:0] {
        LOC_ONCHIP_MEM = 2'h0,
        LOC_ONCHIP_MODULE = 2'h1,
        LOC_EXTERNAL = 2'h2
    } loc_e;
    typedef enum logic [2:0] {
        OP_REG_ALU = 3'h0,
        OP_FLAGS_IMM = 3'h1,
        OP_BRANCH8 = 3'h2,
        OP_BIT_REG = 3'h3,
        OP_BIT_LOGIC_MEM = 3'h4,
        OP_BIT_CLEAR_MEM = 3'h5,
        OP_BIT_SET_MEM = 3'h6,
        OP_SUB_CALL_IND = 3'h7
    } op_class_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } seq_state_e;
    typedef logic [1:0] cnt_t;
    typedef cnt_t [5:0] cnt_vec_t;
    typedef logic [5:0] cost_t;
    typedef logic [7:0] total_t;
    typedef logic [3:0] wait_t;
    typedef struct packed {
        op_class_e op;
        loc_e code_loc;
        loc_e stack_loc;
        loc_e data_loc;
        wait_t waits;
    } exec_req_s;
    typedef struct packed {
        cycle_e ctype;
        logic first_state;
    } cycle_info_s;
endpackage : exec_timing_pkg

// ### src/cpu_execution_state_timing.sv
`timescale 1ns/1ps
`include "exec_timing_defs.svh"
module cpu_execution_state_timing
    import exec_timing_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_start,
    input wire exec_req_s i_req,
    output logic o_busy,
    output logic o_done,
    output cycle_info_s o_cycle,
    output total_t o_total,
    output total_t o_elapsed
);

// ==========================================================
// Decoding functions.
function automatic cnt_vec_t counts_of(input op_class_e op);
    cnt_vec_t c;
    c = '0;
    unique case (op)
        OP_REG_ALU, OP_FLAGS_IMM, OP_BIT_REG: begin
            c[CY_FETCH] = `N_ONE;
        end
        OP_BRANCH8: begin
            c[CY_FETCH] = `N_TWO;
        end
        OP_BIT_LOGIC_MEM: begin
            c[CY_FETCH] = `N_TWO;
            c[CY_BYTE] = `N_ONE;
        end
        OP_BIT_CLEAR_MEM: begin
            c[CY_FETCH] = `N_TWO;
            c[CY_BYTE] = `N_TWO;
        end
        OP_BIT_SET_MEM: begin
            c[CY_FETCH] = `N_TWO;
            c[CY_BYTE] = `N_TWO;
        end
        OP_SUB_CALL_IND: begin
            c[CY_FETCH] = `N_TWO;
            c[CY_BRANCH_READ] = `N_ONE;
            c[CY_STACK] = `N_ONE;
        end
    endcase
    return c;
endfunction : counts_of

function automatic cost_t cost_of(input cycle_e t, input exec_req_s r);
    loc_e l;
    cost_t w2;
    l = r.code_loc;
    if (t == CY_STACK) begin
        l = r.stack_loc;
    end else if (t == CY_BYTE || t == CY_WORD) begin
        l = r.data_loc;
    end
    w2 = {1'b0, r.waits, 1'b0};
    if (t == CY_INTERNAL) begin
        return `COST_INTERNAL;
    end else if (l == LOC_ONCHIP_MEM) begin
        return `COST_ONCHIP_MEM;
    end else if (t == CY_BYTE) begin
        return `COST_BYTE_BASE + ((l == LOC_EXTERNAL) ?
            {2'h0, r.waits} : `COST_RST);
    end
    return `COST_BUS_BASE + ((l == LOC_EXTERNAL) ?
        w2 : `COST_RST);
endfunction : cost_of

function automatic logic [3:0] next_of(input cnt_vec_t c);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 5; i >= 0; i--) begin
        if (c[i] != 2'h0) begin
            n = {1'b1, 3'(i)};
        end
    end
    return n;
endfunction : next_of

function automatic total_t total_of(input cnt_vec_t c,
                                    input exec_req_s r);
    total_t s;
    s = `TOTAL_RST;
    for (int i = 0; i < 6; i++) begin
        s = s + total_t'(c[i]) *
            total_t'(cost_of(cycle_e'(3'(i)), r));
    end
    return s;
endfunction : total_of

// ==========================================================
// Sequencer state.
seq_state_e state_q;
exec_req_s req_q;
cnt_vec_t cnt_q;
cnt_vec_t cnt_d;
cycle_e ty_q;
cost_t left_q;
cost_t len_q;
logic busy_q;
logic done_q;
logic first_q;
total_t total_q;
total_t elapsed_q;
logic [3:0] start_nx;
logic [3:0] run_nx;
cnt_vec_t start_cnt;
logic cyc_end;

assign start_cnt = counts_of(i_req.op);
assign start_nx = next_of(start_cnt);
assign cyc_end = (state_q == ST_RUN) && (left_q == 6'h01);

always_comb begin
    cnt_d = cnt_q;
    cnt_d[ty_q] = cnt_q[ty_q] - 2'h1;
end
assign run_nx = next_of(cnt_d);

always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
        state_q <= ST_IDLE;
        busy_q <= 1'b0;
        done_q <= 1'b0;
    end else if (i_ce) begin
        done_q <= 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (i_start) begin
                    state_q <= ST_RUN;
                    busy_q <= 1'b1;
                end
            end
            ST_RUN: begin
                if (cyc_end && !run_nx[3]) begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
            default: begin
                state_q <= ST_IDLE;
                busy_q <= 1'b0;
            end
        endcase
    end
end

always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
        req_q <= '0;
        cnt_q <= '0;
        ty_q <= CY_FETCH;
        left_q <= `COST_RST;
        first_q <= 1'b0;
    end else if (i_ce) begin
        first_q <= 1'b0;
        if (state_q == ST_IDLE && i_start) begin
            req_q <= i_req;
            cnt_q <= start_cnt;
            ty_q <= cycle_e'(start_nx[2:0]);
            left_q <= cost_of(cycle_e'(start_nx[2:0]), i_req);
            first_q <= 1'b1;
        end else if (cyc_end) begin
            cnt_q <= cnt_d;
            if (run_nx[3]) begin
                ty_q <= cycle_e'(run_nx[2:0]);
                left_q <= cost_of(cycle_e'(run_nx[2:0]), req_q);
                first_q <= 1'b1;
            end
        end else if (state_q == ST_RUN) begin
            left_q <= left_q - 6'h01;
        end
    end
end

always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
        total_q <= `TOTAL_RST;
        elapsed_q <= `TOTAL_RST;
        len_q <= `COST_RST;
    end else if (i_ce) begin
        if (state_q == ST_IDLE && i_start) begin
            total_q <= total_of(start_cnt, i_req);
            elapsed_q <= `TOTAL_RST;
            len_q <= `COST_RST;
        end else if (state_q == ST_RUN) begin
            elapsed_q <= elapsed_q + 8'h01;
            len_q <= cyc_end ? `COST_RST : len_q + 6'h01;
        end
    end
end

assign o_busy = busy_q;
assign o_done = done_q;
assign o_cycle = '{ctype: ty_q, first_state: first_q};
assign o_total = total_q;
assign o_elapsed = elapsed_q;

// ==========================================================
// Checks.
logic go;
logic ce_end;
cost_t n_len;
assign go = i_ce && state_q == ST_IDLE && i_start;
assign ce_end = i_ce && cyc_end;
assign n_len = len_q + 6'h01;

default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (i_srst);

a_total_states_sum: assert property (
    done_q |-> elapsed_q == total_q)
    else $error("elapsed states differ from total");
a_bus_cycle_cost: assert property (
    ce_end && ty_q inside {CY_FETCH, CY_BRANCH_READ} |->
    n_len == ((req_q.code_loc == LOC_ONCHIP_MEM) ? 6'h02 :
    (req_q.code_loc == LOC_EXTERNAL) ?
    6'h06 + {1'b0, req_q.waits, 1'b0} : 6'h06))
    else $error("fetch cycle length wrong");
a_wait_extension: assert property (
    ce_end && ty_q == CY_STACK && req_q.stack_loc == LOC_EXTERNAL
    |-> n_len == 6'h06 + {1'b0, req_q.waits, 1'b0})
    else $error("external stack cycle ignores waits");
a_byte_cost: assert property (
    ce_end && ty_q == CY_BYTE && req_q.data_loc != LOC_ONCHIP_MEM
    |-> n_len == 6'h03 + ((req_q.data_loc == LOC_EXTERNAL) ?
    {2'h0, req_q.waits} : 6'h00))
    else $error("byte access length wrong");
a_word_cost: assert property (
    ce_end && ty_q == CY_WORD && req_q.data_loc != LOC_ONCHIP_MEM
    |-> n_len == 6'h06 + ((req_q.data_loc == LOC_EXTERNAL) ?
    {1'b0, req_q.waits, 1'b0} : 6'h00))
    else $error("word access length wrong");
a_internal_one: assert property (
    i_ce && state_q == ST_RUN && ty_q == CY_INTERNAL |-> cyc_end)
    else $error("internal cycle longer than one state");
a_branch_counts: assert property (
    go && i_req.op == OP_BRANCH8 |=> cnt_q == {10'h0, 2'h2})
    else $error("branch cycle counts wrong");
a_bit_clear_counts: assert property (
    go && i_req.op == OP_BIT_CLEAR_MEM |=>
    cnt_q == {4'h0, 2'h2, 4'h0, 2'h2})
    else $error("bit clear cycle counts wrong");
a_bit_set_run: assert property (
    go && i_req.op == OP_BIT_SET_MEM && i_req.code_loc == LOC_ONCHIP_MEM
    && i_req.data_loc == LOC_ONCHIP_MEM |=> total_q == 8'h08)
    else $error("bit set total wrong");
a_call_counts: assert property (
    go && i_req.op == OP_SUB_CALL_IND |=>
    cnt_q == {6'h00, 2'h1, 2'h1, 2'h2})
    else $error("indirect call cycle counts wrong");
a_onchip_total: assert property (
    go && i_req.op == OP_BRANCH8 && i_req.code_loc == LOC_ONCHIP_MEM
    |=> total_q == 8'h04 ##1 busy_q [*3] ##1 done_q)
    else $error("on-chip branch total wrong");

c_branch_done: cover property (go && i_req.op == OP_BRANCH8 ##[1:20] done_q);
c_ext_fetch: cover property (ce_end && req_q.code_loc == LOC_EXTERNAL);
c_call_stack: cover property (ce_end && ty_q == CY_STACK);
c_bit_clear: cover property (go && i_req.op == OP_BIT_CLEAR_MEM);

endmodule : cpu_execution_state_timing

// ### verification/ext_wait_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side device that decides how many wait states it needs.
module ext_wait_model
    import exec_timing_pkg::*;
(
    input wire wait_t i_need,
    output wait_t o_waits
);
    assign o_waits = i_need;
endmodule : ext_wait_model

// ### verification/cpu_execution_state_timing_tb.sv
`timescale 1ns/1ps
module cpu_execution_state_timing_tb
    import exec_timing_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic start = 1'b0;
    exec_req_s req = '0;
    exec_req_s dut_req;
    wait_t need = 4'h0;
    wait_t waits;
    logic busy, done;
    cycle_info_s cyc_info;
    total_t total, elapsed;
    int bad_count = 0;
    int samples_checked = 0;

    assign dut_req = {req.op, req.code_loc, req.stack_loc, req.data_loc,
        waits};

    cpu_execution_state_timing i_cpu_execution_state_timing (
        .i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_start(start),
        .i_req(dut_req), .o_busy(busy), .o_done(done),
        .o_cycle(cyc_info), .o_total(total), .o_elapsed(elapsed));
    ext_wait_model i_ext_wait_model (.i_need(need), .o_waits(waits));

    initial begin
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Checking helpers.
    task automatic chk(input string what, input total_t seen,
            input total_t exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk

    function automatic int bus_c(input loc_e l, input int m);
        if (l == LOC_ONCHIP_MEM) return 2;
        if (l == LOC_EXTERNAL) return 6 + 2 * m;
        return 6;
    endfunction : bus_c

    function automatic int byte_c(input loc_e l, input int m);
        if (l == LOC_ONCHIP_MEM) return 2;
        if (l == LOC_EXTERNAL) return 3 + m;
        return 3;
    endfunction : byte_c

    task automatic run_op(input op_class_e op, input loc_e cl, input loc_e sl,
            input loc_e dl, input int m, input int stall, input bit poke);
        int n, cy, f, b, exp;
        total_t hold;
        f = (op == OP_REG_ALU || op == OP_FLAGS_IMM || op == OP_BIT_REG)
            ? 1 : 2;
        b = (op == OP_BIT_LOGIC_MEM) ? 1 :
            (op == OP_BIT_CLEAR_MEM || op == OP_BIT_SET_MEM) ? 2 : 0;
        exp = f * bus_c(cl, m) + b * byte_c(dl, m);
        if (op == OP_SUB_CALL_IND) exp = exp + bus_c(cl, m) + bus_c(sl, m);
        @(negedge clk);
        req = '{op, cl, sl, dl, 4'h0};
        need = m[3:0];
        start = 1'b1;
        @(negedge clk);
        n = 0;
        cy = (cyc_info.first_state === 1'b1) ? 1 : 0;
        chk("busy", total_t'(busy), 8'h01);
        chk("first type", total_t'(cyc_info.ctype), 8'h00);
        if (poke) begin
            req.op = OP_REG_ALU;
            @(negedge clk);
            n = 1;
        end
        start = 1'b0;
        while (n < 300) begin
            @(posedge clk);
            n++;
            #1;
            if (done === 1'b1) break;
            if (cyc_info.first_state === 1'b1) cy++;
            if (stall > 0 && n == 3) begin
                hold = elapsed;
                @(negedge clk);
                ce = 1'b0;
                repeat (stall) @(negedge clk);
                ce = 1'b1;
                chk("stalled elapsed", elapsed, hold);
            end
        end
        chk("total", total, total_t'(exp));
        chk("elapsed", elapsed, total_t'(exp));
        chk("edges to done", total_t'(n), total_t'(exp));
        chk("run limit", total_t'(n >= 300), 8'h00);
        chk("cycles", total_t'(cy), total_t'(f + b + ((op ==
            OP_SUB_CALL_IND) ? 2 : 0)));
    endtask : run_op

    // ==========================================================
    // Scenarios.
    task automatic t_classes();
        for (int i = 0; i < 8; i++) begin
            run_op(op_class_e'(i), LOC_ONCHIP_MEM, LOC_ONCHIP_MEM,
                LOC_ONCHIP_MEM, 0, 0, 1'b0);
        end
        $display("test classes done");
    endtask : t_classes

    task automatic t_locations();
        for (int i = 0; i < 4; i++) begin
            run_op(OP_BIT_SET_MEM, loc_e'(i), LOC_EXTERNAL, loc_e'(3 - i),
                1, 0, 1'b0);
            run_op(OP_SUB_CALL_IND, loc_e'(i), loc_e'(3 - i), LOC_EXTERNAL,
                1, 0, 1'b0);
        end
        $display("test locations done");
    endtask : t_locations

    task automatic t_waits();
        int ms[3] = '{0, 7, 15};
        foreach (ms[k]) begin
            run_op(OP_SUB_CALL_IND, LOC_EXTERNAL, LOC_EXTERNAL,
                LOC_EXTERNAL, ms[k], 0, 1'b0);
            run_op(OP_BIT_CLEAR_MEM, LOC_EXTERNAL, LOC_EXTERNAL,
                LOC_EXTERNAL, ms[k], 0, 1'b0);
        end
        $display("test waits done");
    endtask : t_waits

    task automatic t_stall_and_reset();
        run_op(OP_BIT_LOGIC_MEM, LOC_EXTERNAL, LOC_ONCHIP_MEM,
            LOC_EXTERNAL, 3, 4, 1'b1);
        run_op(OP_BRANCH8, LOC_ONCHIP_MODULE, LOC_ONCHIP_MEM,
            LOC_ONCHIP_MEM, 0, 0, 1'b0);
        @(negedge clk);
        req.op = OP_SUB_CALL_IND;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        chk("reset busy", total_t'(busy), 8'h00);
        chk("reset total", total, 8'h00);
        chk("reset elapsed", elapsed, 8'h00);
        @(posedge clk);
        #1;
        chk("idle after reset", total_t'(busy), 8'h00);
        run_op(OP_FLAGS_IMM, LOC_ONCHIP_MEM, LOC_ONCHIP_MEM,
            LOC_ONCHIP_MEM, 0, 0, 1'b0);
        $display("test stall and reset done");
    endtask : t_stall_and_reset

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk("idle total", total, 8'h00);
        t_classes();
        t_locations();
        t_waits();
        t_stall_and_reset();
        finish_test();
    end

    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule : cpu_execution_state_timing_tb
